/* core/aims_pkg.sv */
// Constants for the analog input multiplexer select block.
// Assumes a classic Wishbone slave with 32-bit data, word aligned.
package aims_pkg;
    // Register byte addresses
    localparam logic [3:0] AIMS_TRIO_ADDR = 4'h0;
    localparam logic [3:0] AIMS_ZERO_ADDR = 4'h4;
    localparam logic [3:0] AIMS_MODE_ADDR = 4'h8;
    localparam logic [3:0] AIMS_ROUTE_ADDR = 4'hc;
    // Trio select field positions
    localparam int AIMS_TRIO_POS_A = 0;
    localparam int AIMS_TRIO_NEG_A_LO = 1;
    localparam int AIMS_TRIO_POS_B = 8;
    localparam int AIMS_TRIO_NEG_B_LO = 9;
    // Channel zero select field positions
    localparam int AIMS_ZERO_POS_A_LO = 0;
    localparam int AIMS_ZERO_NEG_A = 7;
    localparam int AIMS_ZERO_POS_B_LO = 8;
    localparam int AIMS_ZERO_NEG_B = 15;
    // Writable masks
    localparam logic [15:0] AIMS_TRIO_MASK = 16'h0707;
    localparam logic [15:0] AIMS_ZERO_MASK = 16'h9f9f;
    // Reset values
    localparam logic [15:0] AIMS_TRIO_RST = 16'h0000;
    localparam logic [15:0] AIMS_ZERO_RST = 16'h0000;
    localparam logic AIMS_MODE_RST = 1'b0;
    // Highest legal channel zero positive input number, both variants
    localparam logic [4:0] AIMS_ZERO_MAX = 5'h0c;
    // Input number meaning the negative reference
    localparam logic [3:0] AIMS_VREF_SEL = 4'hf;
    // Mux selection encodings
    typedef enum logic [1:0] {
        AIMS_ROUTE_INPUT,
        AIMS_ROUTE_VREF,
        AIMS_ROUTE_RESERVED
    } aims_route_kind_t;
endpackage

/* core/aims_trio_decode.sv */
// Decodes trio negative and positive select codes into analog inputs.
// Assumes the caller supplies the mode and variant as steady levels.
`timescale 1ns/1ps
`default_nettype none
module aims_trio_decode (
    input wire logic [1:0] i_neg_sel,
    input wire logic i_pos_sel,
    input wire logic i_twelve_bit_mode,
    input wire logic i_large_pkg,
    output logic [11:0] o_pos_inputs,
    output logic [11:0] o_neg_inputs,
    output logic o_reserved
);
    function automatic logic [11:0] pack3(input logic [3:0] base);
        pack3 = {base + 4'h2, base + 4'h1, base};
    endfunction

    always_comb begin
        o_reserved = 1'b0;
        o_pos_inputs = '0;
        o_neg_inputs = {3{aims_pkg::AIMS_VREF_SEL}};
        if (i_twelve_bit_mode) begin
            o_reserved = 1'b1; // [RL9]
        end else begin
            o_pos_inputs = i_pos_sel ? pack3(4'h3) : pack3(4'h0); // [RL6] [RL7]
            unique case (i_neg_sel)
                2'b11: o_neg_inputs = pack3(4'h9); // [RL2]
                2'b10: begin
                    if (i_large_pkg) begin
                        o_neg_inputs = pack3(4'h6); // [RL3]
                    end else begin
                        o_reserved = 1'b1; // [RL3]
                    end
                end
                2'b01, 2'b00: o_neg_inputs = {3{aims_pkg::AIMS_VREF_SEL}}; // [RL4]
            endcase
        end
    end
endmodule
`default_nettype wire

/* core/aims_zero_decode.sv */
// Decodes channel zero positive and negative selects.
// Assumes the caller supplies the variant as a steady level.
`timescale 1ns/1ps
`default_nettype none
module aims_zero_decode (
    input wire logic [4:0] i_pos_sel,
    input wire logic i_neg_sel,
    input wire logic i_large_pkg,
    output logic [3:0] o_pos_input,
    output logic [3:0] o_neg_input,
    output logic o_reserved
);
    always_comb begin
        o_pos_input = i_pos_sel[3:0]; // [RL10]
        o_reserved = 1'b0;
        if (i_pos_sel > aims_pkg::AIMS_ZERO_MAX) begin
            o_reserved = 1'b1;
        end else if (!i_large_pkg && i_pos_sel >= 5'h06
                     && i_pos_sel <= 5'h08) begin
            o_reserved = 1'b1;
        end
        o_neg_input = i_neg_sel ? 4'h1 : aims_pkg::AIMS_VREF_SEL; // [RL11]
    end
endmodule
`default_nettype wire

/* core/aims_select.sv */
// Register file and routing for the converter input multiplexers.
// Assumes a classic Wishbone master on i_sys_clk; one clock domain.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RL1] Trio negative select A at bits 2:1
// [RL2] Ten-bit neg code 11 routes inputs 9-11
// [RL3] Neg code 10 routes 6-8, large only
// [RL4] Neg codes 01, 00 route negative reference
// [RL5] Trio positive select A at bit 0
// [RL6] Positive select 1 routes inputs 3-5
// [RL7] Positive select 0 routes inputs 0-2
// [RL8] Trio bits 7:3 read zero, ignore writes
// [RL9] Twelve-bit mode makes trio codes reserved
// [RL10] Zero positive code equals input number
// [RL11] Zero negative bit: input 1 or reference
// [RL12] Slot picks A or B fields; reset zero
module aims_select #(
    parameter bit LARGE_PKG = 1'b1
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_wb_err,
    input wire logic i_sample_b,
    output logic [11:0] o_trio_pos_inputs,
    output logic [11:0] o_trio_neg_inputs,
    output logic [3:0] o_zero_pos_input,
    output logic [3:0] o_zero_neg_input,
    output logic o_route_reserved
);
    typedef struct packed {
        logic [15:0] trio;
        logic [15:0] zero;
        logic twelve_bit_mode;
        logic ack;
        logic err;
        logic [31:0] rdat;
        logic [11:0] tpos;
        logic [11:0] tneg;
        logic [3:0] zpos;
        logic [3:0] zneg;
        logic resv;
    } aims_state_t;

    aims_state_t st_reg;
    aims_state_t st_next;

    logic [1:0] trio_neg;
    logic trio_pos;
    logic [4:0] zero_pos;
    logic zero_neg;
    logic [11:0] dec_tpos;
    logic [11:0] dec_tneg;
    logic dec_tres;
    logic [3:0] dec_zpos;
    logic [3:0] dec_zneg;
    logic dec_zres;
    logic req;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel,
                                            input logic [15:0] mask);
        logic [15:0] m;
        m = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        merge16 = (old & ~m) | (wd[15:0] & m);
    endfunction

    // Choose the active slot's fields
    always_comb begin
        if (i_sample_b) begin
            trio_neg = st_reg.trio[aims_pkg::AIMS_TRIO_NEG_B_LO +: 2];
            trio_pos = st_reg.trio[aims_pkg::AIMS_TRIO_POS_B];
            zero_pos = st_reg.zero[aims_pkg::AIMS_ZERO_POS_B_LO +: 5];
            zero_neg = st_reg.zero[aims_pkg::AIMS_ZERO_NEG_B];
        end else begin
            trio_neg = st_reg.trio[aims_pkg::AIMS_TRIO_NEG_A_LO +: 2]; // [RL1]
            trio_pos = st_reg.trio[aims_pkg::AIMS_TRIO_POS_A]; // [RL5]
            zero_pos = st_reg.zero[aims_pkg::AIMS_ZERO_POS_A_LO +: 5];
            zero_neg = st_reg.zero[aims_pkg::AIMS_ZERO_NEG_A];
        end // [RL12]
    end

    aims_trio_decode u_trio (
        .i_neg_sel(trio_neg),
        .i_pos_sel(trio_pos),
        .i_twelve_bit_mode(st_reg.twelve_bit_mode),
        .i_large_pkg(LARGE_PKG),
        .o_pos_inputs(dec_tpos),
        .o_neg_inputs(dec_tneg),
        .o_reserved(dec_tres)
    );

    aims_zero_decode u_zero (
        .i_pos_sel(zero_pos),
        .i_neg_sel(zero_neg),
        .i_large_pkg(LARGE_PKG),
        .o_pos_input(dec_zpos),
        .o_neg_input(dec_zneg),
        .o_reserved(dec_zres)
    );

    assign req = i_wb_cyc && i_wb_stb && !st_reg.ack && !st_reg.err;

    always_comb begin
        st_next = st_reg;
        st_next.ack = 1'b0;
        st_next.err = 1'b0;
        st_next.tpos = dec_tpos;
        st_next.tneg = dec_tneg;
        st_next.zpos = dec_zpos;
        st_next.zneg = dec_zneg;
        st_next.resv = dec_tres || dec_zres;
        if (req) begin
            st_next.ack = 1'b1;
            st_next.rdat = '0;
            unique case (i_wb_adr)
                aims_pkg::AIMS_TRIO_ADDR: begin
                    if (i_wb_we) begin
                        st_next.trio = merge16(st_reg.trio, i_wb_dat,
                            i_wb_sel, aims_pkg::AIMS_TRIO_MASK); // [RL8]
                    end
                    st_next.rdat[15:0] = st_reg.trio & aims_pkg::AIMS_TRIO_MASK; // [RL8]
                end
                aims_pkg::AIMS_ZERO_ADDR: begin
                    if (i_wb_we) begin
                        st_next.zero = merge16(st_reg.zero, i_wb_dat,
                            i_wb_sel, aims_pkg::AIMS_ZERO_MASK);
                    end
                    st_next.rdat[15:0] = st_reg.zero & aims_pkg::AIMS_ZERO_MASK;
                end
                aims_pkg::AIMS_MODE_ADDR: begin
                    if (i_wb_we && i_wb_sel[0]) begin
                        st_next.twelve_bit_mode = i_wb_dat[0];
                    end
                    st_next.rdat[0] = st_reg.twelve_bit_mode;
                end
                aims_pkg::AIMS_ROUTE_ADDR: begin
                    st_next.rdat[3:0] = st_reg.zpos;
                    st_next.rdat[7:4] = st_reg.zneg;
                    st_next.rdat[8] = st_reg.resv;
                end
                default: begin
                    st_next.ack = 1'b0;
                    st_next.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= '0;
            st_reg.trio <= aims_pkg::AIMS_TRIO_RST; // [RL12]
            st_reg.zero <= aims_pkg::AIMS_ZERO_RST;
            st_reg.twelve_bit_mode <= aims_pkg::AIMS_MODE_RST;
            st_reg.tneg <= {3{aims_pkg::AIMS_VREF_SEL}};
            st_reg.zneg <= aims_pkg::AIMS_VREF_SEL;
        end else if (i_clk_en) begin
            st_reg <= st_next;
        end
    end

    assign o_wb_dat = st_reg.rdat;
    assign o_wb_ack = st_reg.ack;
    assign o_wb_err = st_reg.err;
    assign o_trio_pos_inputs = st_reg.tpos;
    assign o_trio_neg_inputs = st_reg.tneg;
    assign o_zero_pos_input = st_reg.zpos;
    assign o_zero_neg_input = st_reg.zneg;
    assign o_route_reserved = st_reg.resv;
endmodule
`default_nettype wire

/* tb/aims_select_monitor.sv */
// Checker for the input mux select block, bound to its top module.
// Assumes one clock domain; the bench pulls i_clk_en low only when idle.
`timescale 1ns/1ps
`default_nettype none
module aims_select_chk (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic o_wb_err,
    input wire logic [11:0] o_trio_pos_inputs,
    input wire logic [11:0] o_trio_neg_inputs,
    input wire logic [3:0] o_zero_pos_input,
    input wire logic [3:0] o_zero_neg_input
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_req_answered: assert property (i_clk_en && i_wb_cyc && i_wb_stb
        && !o_wb_ack && !o_wb_err |=> o_wb_ack || o_wb_err)
        else $error("request not answered next cycle");
    a_trio_pos_legal: assert property (
        o_trio_pos_inputs inside {12'h210, 12'h543, 12'h000})
        else $error("trio positive routing illegal");
    a_trio_neg_legal: assert property (
        o_trio_neg_inputs inside {12'hfff, 12'hba9, 12'h876})
        else $error("trio negative routing illegal");
    a_zero_neg_legal: assert property (
        o_zero_neg_input inside {4'h1, 4'hf})
        else $error("zero negative routing illegal");
    a_reserved_ref: assert property (
        o_trio_pos_inputs == 12'h000 |-> o_trio_neg_inputs == 12'hfff)
        else $error("reserved trio not on reference");
    a_trio_read_zero: assert property (o_wb_ack && !$past(i_wb_we)
        && $past(i_wb_adr) == aims_pkg::AIMS_TRIO_ADDR
        |-> o_wb_dat[7:3] == 5'h00)
        else $error("trio unused bits read nonzero");
    a_zero_pos_range: assert property (
        o_zero_pos_input <= 4'hc)
        else $error("zero positive input out of range");
    a_freeze_hold: assert property (!i_clk_en |=>
        $stable(o_trio_neg_inputs) && $stable(o_zero_neg_input)
        && $stable(o_wb_ack))
        else $error("state moved while clock enable low");
    a_reset_values: assert property ($past(i_sys_rst)
        |-> o_trio_neg_inputs == 12'hfff && o_zero_neg_input == 4'hf)
        else $error("routing not at reset value");
endmodule
bind aims_select aims_select_chk aims_select_chk_i (.i_sys_clk, .i_sys_rst,
    .i_clk_en, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat,
    .o_wb_ack, .o_wb_err, .o_trio_pos_inputs, .o_trio_neg_inputs,
    .o_zero_pos_input, .o_zero_neg_input);
`default_nettype wire

/* tb/aims_select_tb_top.sv */
// Self-checking bench for the input mux select block.
// Assumes the design and its checker are compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
module aims_select_tb_top;
    typedef struct packed {
        logic [15:0] trio;
        logic [15:0] zero;
        logic mode;
        logic sb;
        logic [11:0] pos;
        logic [11:0] neg;
        logic [3:0] zp;
        logic [3:0] zn;
        logic res;
    } aims_row_t;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic sb = 1'b0;
    logic ce = 1'b1;
    logic e, ack, err, res;
    logic [3:0] adr = 4'h0;
    logic [3:0] zp, zn;
    logic [11:0] tp, tn;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, got;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    aims_row_t rows [6] = '{
        '{16'h0000, 16'h0000, 1'b0, 1'b0, 12'h210, 12'hfff, 4'h0, 4'hf, 1'b0},
        '{16'h0007, 16'h008c, 1'b0, 1'b0, 12'h543, 12'hba9, 4'hc, 4'h1, 1'b0},
        '{16'h0005, 16'h0081, 1'b0, 1'b0, 12'h543, 12'h876, 4'h1, 4'h1, 1'b0},
        '{16'h0003, 16'h0000, 1'b0, 1'b0, 12'h543, 12'hfff, 4'h0, 4'hf, 1'b0},
        '{16'h0700, 16'h8300, 1'b0, 1'b1, 12'h543, 12'hba9, 4'h3, 4'h1, 1'b0},
        '{16'h00f9, 16'h0002, 1'b1, 1'b0, 12'h000, 12'hfff, 4'h2, 4'hf, 1'b1}
    };
    aims_select #(.LARGE_PKG(1'b1)) aims_select_i (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(ce), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h3),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
        .i_sample_b(sb), .o_trio_pos_inputs(tp), .o_trio_neg_inputs(tn),
        .o_zero_pos_input(zp), .o_zero_neg_input(zn), .o_route_reserved(res));
    always #50 clk = ~clk;
    task automatic print_verdict();
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // One classic cycle; the watchdog bounds the wait for an answer
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic f);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && err !== 1'b1) @(posedge clk);
        q = rdat;
        f = (err === 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[k]) begin
            wb(1'b1, aims_pkg::AIMS_TRIO_ADDR, 32'(rows[k].trio), got, e);
            wb(1'b1, aims_pkg::AIMS_ZERO_ADDR, 32'(rows[k].zero), got, e);
            wb(1'b1, aims_pkg::AIMS_MODE_ADDR, 32'(rows[k].mode), got, e);
            sb <= rows[k].sb;
            wb(1'b0, aims_pkg::AIMS_TRIO_ADDR, 32'h0, got, e);
            check(got, 32'(rows[k].trio & 16'h0707));
            check(32'(tp), 32'(rows[k].pos));
            check(32'(tn), 32'(rows[k].neg));
            check(32'(zp), 32'(rows[k].zp));
            check(32'(zn), 32'(rows[k].zn));
            check(32'(res), 32'(rows[k].res));
        end
        // Leave routing off its reset values, then freeze with enable low
        wb(1'b1, aims_pkg::AIMS_MODE_ADDR, 32'h0, got, e);
        wb(1'b1, aims_pkg::AIMS_TRIO_ADDR, 32'h7, got, e);
        wb(1'b1, aims_pkg::AIMS_ZERO_ADDR, 32'h80, got, e);
        ce <= 1'b0;
        sb <= 1'b1;
        repeat (3) @(posedge clk);
        check(32'(tn), 32'hba9);
        check(32'(zn), 32'h1);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        check(32'(tn), 32'hfff);
        check(32'(tp), 32'h210);
        check(32'(zn), 32'hf);
        sb <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'(tn), 32'hba9);
        check(32'(zn), 32'h1);
        // Mid-run reset must clear every select field
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        check(32'(tn), 32'hfff);
        check(32'(zn), 32'hf);
        wb(1'b0, aims_pkg::AIMS_TRIO_ADDR, 32'h0, got, e);
        check(got, 32'h0);
        check(32'(tp), 32'h210);
        wb(1'b0, aims_pkg::AIMS_ZERO_ADDR, 32'h0, got, e);
        check(got, 32'h0);
        wb(1'b0, aims_pkg::AIMS_ROUTE_ADDR, 32'h0, got, e);
        check(got, 32'h0f0);
        wb(1'b1, 4'h2, 32'h0, got, e);
        check(32'(e), 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
